// >>> pkg/sew_pkg.sv
// package: constants and state types for the serial eeprom write-busy/protect slave
package sew_pkg;
    localparam int unsigned CLK_HZ        = 100_000_000;
    localparam int unsigned TWR_TYP_MS    = 5;
    localparam int unsigned TWR_MAX_MS    = 10;
    localparam int unsigned TWR_TYP_CYC   = TWR_TYP_MS * (CLK_HZ / 1000);
    localparam int unsigned TWR_MAX_CYC   = TWR_MAX_MS * (CLK_HZ / 1000);
    localparam int          TMR_W         = 20;
    localparam int          ADDR_W        = 8;
    localparam int          MEM_WORDS     = 256;
    localparam logic [3:0]  DEV_TYPE      = 4'hA;
    localparam logic [3:0]  BITS_PER_BYTE = 4'h8;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_DEV   = 3'b001,
        ST_WADDR = 3'b010,
        ST_WDATA = 3'b011,
        ST_ACK   = 3'b100,
        ST_RDATA = 3'b101,
        ST_MACK  = 3'b110,
        ST_SKIP  = 3'b111
    } sew_state_e;

    typedef struct packed {
        logic [1:0]        scl_sync;
        logic [1:0]        sda_sync;
        logic              scl_prev;
        logic              sda_prev;
        sew_state_e        state;
        sew_state_e        ret;
        logic [3:0]        cnt;
        logic [7:0]        sh;
        logic [ADDR_W-1:0] ptr;
        logic [ADDR_W-1:0] waddr;
        logic [7:0]        wdata;
        logic              pend;
        logic              mack;
        logic              oe;
        logic              busy;
        logic [TMR_W-1:0]  tmr;
        logic [1:0]        wp_sync;
        logic [1:0]        en_sync;
        logic              prog_en;
    } sew_regs_s;
endpackage

// >>> rtl/sew_eeprom_slave.sv
// two-wire eeprom slave with busy polling, upper-half write protect and program disable
// Summary of operation
// - while the internal write runs the slave address is not acknowledged; afterwards it is.
// - the busy indication lasts exactly as long as the internal write, about 5 ms typically.
// - an asserted write-protect input forbids writes to the upper half of the array.
// - a protected write acknowledges slave and word address, refuses the data and never programs.
// - after reset programming is disabled and every write is aborted until enabled.
// - a write overwrites the location directly, one data change, no erase.
// - reads never change the array and are unlimited.
// - the address counter holds last accessed address plus one for current-address reads.
// - the slave answers only to device type 1010.
// - the internal write never exceeds 10 ms.
`timescale 1ns/100ps
`default_nettype none
module sew_eeprom_slave #(
    parameter int unsigned WRITE_CYCLES = sew_pkg::TWR_TYP_CYC
) (
    input  wire logic       clk_i,
    input  wire logic       reset_n_i,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe_o,
    input  wire logic [2:0] dev_addr_i,
    input  wire logic       write_protect_i,
    input  wire logic       prog_enable_i,
    output logic            busy_o
);
    sew_pkg::sew_regs_s st;
    sew_pkg::sew_regs_s next_st;
    logic [7:0]         mem [sew_pkg::MEM_WORDS];
    logic               scl;
    logic               sda;
    logic               scl_rise;
    logic               scl_fall;
    logic               start_cond;
    logic               stop_cond;
    logic               commit;

    assign scl        = st.scl_sync[1];
    assign sda        = st.sda_sync[1];
    assign scl_rise   = scl & ~st.scl_prev;
    assign scl_fall   = ~scl & st.scl_prev;
    assign start_cond = scl & st.scl_prev & st.sda_prev & ~sda;
    assign stop_cond  = scl & st.scl_prev & ~st.sda_prev & sda;
    // programming only at the stop, and only if enabled when the stop arrives
    assign commit     = stop_cond & st.pend & st.prog_en;

    always_comb
    begin
        next_st          = st;
        next_st.scl_sync = {st.scl_sync[0], scl_i};
        next_st.sda_sync = {st.sda_sync[0], sda_i};
        next_st.wp_sync  = {st.wp_sync[0], write_protect_i};
        next_st.en_sync  = {st.en_sync[0], prog_enable_i};
        next_st.scl_prev = scl;
        next_st.sda_prev = sda;
        next_st.prog_en  = st.en_sync[1];

        // self-timed cycle: busy for exactly WRITE_CYCLES clocks
        if (st.busy)
        begin
            if (st.tmr == '0)
                next_st.busy = 1'b0;
            else
                next_st.tmr = st.tmr - 1'b1;
        end

        if (start_cond)
        begin
            next_st.state = sew_pkg::ST_DEV;
            next_st.cnt   = '0;
            next_st.oe    = 1'b0;
            next_st.pend  = 1'b0;
        end
        else if (stop_cond)
        begin
            next_st.state = sew_pkg::ST_IDLE;
            next_st.oe    = 1'b0;
            next_st.pend  = 1'b0;
            if (commit)
            begin
                next_st.busy = 1'b1;
                next_st.tmr  = WRITE_CYCLES[sew_pkg::TMR_W-1:0] - 1'b1;
            end
        end
        else
        begin
            case (st.state)
                sew_pkg::ST_DEV, sew_pkg::ST_WADDR, sew_pkg::ST_WDATA:
                begin
                    if (scl_rise)
                    begin
                        next_st.sh  = {st.sh[6:0], sda};
                        next_st.cnt = st.cnt + 4'h1;
                    end
                    else if (scl_fall && st.cnt == sew_pkg::BITS_PER_BYTE)
                    begin
                        next_st.cnt   = '0;
                        next_st.state = sew_pkg::ST_SKIP;
                        if (st.state == sew_pkg::ST_DEV)
                        begin
                            // busy refuses every address, which is what polling looks for
                            if (st.sh[7:4] == sew_pkg::DEV_TYPE && st.sh[3:1] == dev_addr_i
                                && !st.busy)
                            begin
                                next_st.oe    = 1'b1;
                                next_st.state = sew_pkg::ST_ACK;
                                next_st.ret   = st.sh[0] ? sew_pkg::ST_RDATA : sew_pkg::ST_WADDR;
                            end
                        end
                        else if (st.state == sew_pkg::ST_WADDR)
                        begin
                            next_st.ptr   = st.sh;
                            next_st.oe    = 1'b1;
                            next_st.state = sew_pkg::ST_ACK;
                            next_st.ret   = sew_pkg::ST_WDATA;
                        end
                        else if (!(st.wp_sync[1] && st.ptr[sew_pkg::ADDR_W-1]))
                        begin
                            next_st.waddr = st.ptr;
                            next_st.wdata = st.sh;
                            next_st.pend  = 1'b1;
                            next_st.ptr   = st.ptr + 1'b1;
                            next_st.oe    = 1'b1;
                            next_st.state = sew_pkg::ST_ACK;
                            next_st.ret   = sew_pkg::ST_SKIP;
                        end
                        // protected data byte: no ack and nothing pending
                    end
                end
                sew_pkg::ST_ACK:
                begin
                    if (scl_fall)
                    begin
                        next_st.state = st.ret;
                        next_st.oe    = 1'b0;
                        if (st.ret == sew_pkg::ST_RDATA)
                        begin
                            next_st.sh  = mem[st.ptr];
                            next_st.ptr = st.ptr + 1'b1;
                            next_st.oe  = ~mem[st.ptr][7];
                        end
                    end
                end
                sew_pkg::ST_RDATA:
                begin
                    if (scl_rise)
                        next_st.cnt = st.cnt + 4'h1;
                    else if (scl_fall)
                    begin
                        if (st.cnt == sew_pkg::BITS_PER_BYTE)
                        begin
                            next_st.oe    = 1'b0;
                            next_st.cnt   = '0;
                            next_st.state = sew_pkg::ST_MACK;
                        end
                        else
                        begin
                            next_st.sh = {st.sh[6:0], 1'b0};
                            next_st.oe = ~st.sh[6];
                        end
                    end
                end
                sew_pkg::ST_MACK:
                begin
                    if (scl_rise)
                        next_st.mack = ~sda;
                    else if (scl_fall)
                    begin
                        if (st.mack)
                        begin
                            // sequential read; counter rolls over at the top
                            next_st.sh    = mem[st.ptr];
                            next_st.ptr   = st.ptr + 1'b1;
                            next_st.oe    = ~mem[st.ptr][7];
                            next_st.state = sew_pkg::ST_RDATA;
                        end
                        else
                            next_st.state = sew_pkg::ST_SKIP;
                    end
                end
                sew_pkg::ST_IDLE, sew_pkg::ST_SKIP:
                begin
                    next_st.oe = 1'b0;
                end
                default:
                begin
                    next_st.state = sew_pkg::ST_IDLE;
                    next_st.oe    = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            st          <= '0;
            st.scl_sync <= 2'h3;
            st.sda_sync <= 2'h3;
            st.scl_prev <= 1'b1;
            st.sda_prev <= 1'b1;
            st.state    <= sew_pkg::ST_IDLE;
            st.ret      <= sew_pkg::ST_IDLE;
        end
        else
            st <= next_st;
    end

    // one direct overwrite per accepted write, no erase pass
    always_ff @(posedge clk_i)
    begin
        if (commit)
            mem[st.waddr] <= st.wdata;
    end

    assign sda_o    = 1'b0;
    assign sda_oe_o = st.oe;
    assign busy_o   = st.busy;
endmodule // sew_eeprom_slave
`default_nettype wire

// >>> testbench/sew_monitor.sv
// checker for the eeprom slave port behaviour
`timescale 1ns/100ps
`default_nettype none
module sew_monitor #(
    parameter int unsigned WRITE_CYCLES = 600
) (
    input wire logic       clk_i,
    input wire logic       reset_n_i,
    input wire logic       scl_i,
    input wire logic       sda_i,
    input wire logic       sda_o,
    input wire logic       sda_oe_o,
    input wire logic [2:0] dev_addr_i,
    input wire logic       write_protect_i,
    input wire logic       prog_enable_i,
    input wire logic       busy_o
);
    int unsigned bcnt;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    // run length of busy, so its exact duration can be judged at the falling edge
    always_ff @(posedge clk_i) bcnt <= (busy_o && reset_n_i) ? bcnt + 32'h1 : '0;
    a_busy_len_exact: assert property ($fell(busy_o) |-> bcnt == WRITE_CYCLES)
        else $error("busy length differs from write time");
    a_busy_under_max: assert property (busy_o |-> bcnt < sew_pkg::TWR_MAX_CYC)
        else $error("busy longer than maximum write time");
    a_busy_no_ack: assert property (busy_o |-> !sda_oe_o)
        else $error("acknowledge while busy");
    a_busy_at_stop: assert property ($rose(busy_o) |-> scl_i && sda_i)
        else $error("busy began outside a stop");
    a_busy_holds_on: assert property ($rose(busy_o) |=> busy_o [*8])
        else $error("busy dropped early");
    a_busy_needs_enable: assert property ($rose(busy_o) |-> $past(prog_enable_i, 8))
        else $error("write started with programming disabled");
    a_reset_quiet_out: assert property ($rose(reset_n_i) |-> !busy_o && !sda_oe_o)
        else $error("outputs active after reset");
    a_ack_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i)
        else $error("data line moved while clock high");
    a_ack_bounded: assert property ($rose(sda_oe_o) |-> ##[1:400] !sda_oe_o)
        else $error("data line held too long");
    // open drain: whenever the enable is up the line must be pulled low, never driven high
    a_ack_drives_low: assert property (sda_oe_o |-> !sda_o)
        else $error("data line driven high");
endmodule // sew_monitor

bind sew_eeprom_slave sew_monitor #(.WRITE_CYCLES(WRITE_CYCLES)) sew_monitor_i (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
    .sda_oe_o(sda_oe_o), .dev_addr_i(dev_addr_i), .write_protect_i(write_protect_i),
    .prog_enable_i(prog_enable_i), .busy_o(busy_o));
`default_nettype wire

// >>> testbench/sew_master_model.sv
// two-wire bus master model: drives the serial clock and pulls data low
`timescale 1ns/100ps
`default_nettype none
module sew_master_model #(
    parameter int Q = 8
) (
    input  wire logic clk_i,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_low_o
);
    initial
    begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end
    // each bus phase lasts Q clocks, the clock-high phase of a bit 2Q, well above the synchroniser delay
    task automatic q(input int n = 1);
        repeat (n * Q) @(negedge clk_i);
    endtask
    task automatic start();
        sda_low_o = 1'b0;
        q();
        scl_o = 1'b1;
        q();
        sda_low_o = 1'b1;
        q();
        scl_o = 1'b0;
        q();
    endtask
    task automatic stop();
        sda_low_o = 1'b1;
        q();
        scl_o = 1'b1;
        q();
        sda_low_o = 1'b0;
        q();
    endtask
    task automatic bit_x(input logic b, output logic r);
        sda_low_o = ~b;
        q();
        scl_o = 1'b1;
        q(2);
        r = sda_i;
        scl_o = 1'b0;
        q();
    endtask
    // sending FF releases the line so the slave can drive read data
    task automatic xfer(input logic [7:0] d, input logic mack, output logic [7:0] r, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--)
        begin
            bit_x(d[i], b);
            r[i] = b;
        end
        bit_x(~mack, b);
        ack = ~b;
    endtask
endmodule // sew_master_model
`default_nettype wire

// >>> testbench/serial_eeprom_write_busy_protect_bench.sv
// self-checking bench for the eeprom write busy and protect slave
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin num_errors++; $display("BAD %s exp %0h got %0h", n, e, s); end end
module serial_eeprom_write_busy_protect_bench;
    localparam int unsigned WC = 600;
    typedef struct packed {logic wp; logic en; logic [7:0] a; logic [7:0] d;} sew_row_s;
    logic       clk_i = 1'b0;
    logic       reset_n_i = 1'b0;
    logic       write_protect_i = 1'b0;
    logic       prog_enable_i = 1'b0;
    logic       scl, sda_low, sda_oe, busy, sda;
    logic [7:0] mem [256];
    logic [7:0] bad [3] = '{8'hBA, 8'h2A, 8'hA2};
    int         num_errors = 0;
    int         checks = 0;
    sew_row_s   rows [7] = '{'{1'b0, 1'b1, 8'h10, 8'h5A}, '{1'b0, 1'b1, 8'h90, 8'hC3}, '{1'b1, 1'b1, 8'h90, 8'h11},
        '{1'b1, 1'b1, 8'h7F, 8'h3C}, '{1'b0, 1'b0, 8'h10, 8'h77}, '{1'b0, 1'b1, 8'h10, 8'hA5},
        '{1'b0, 1'b1, 8'h8F, 8'hE1}};
    // open-drain data line with pull-up
    assign sda = ~(sda_oe | sda_low);
    always #5 clk_i = ~clk_i;
    sew_eeprom_slave #(.WRITE_CYCLES(WC)) sew_eeprom_slave_i (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe),
        .dev_addr_i(3'h5), .write_protect_i(write_protect_i), .prog_enable_i(prog_enable_i), .busy_o(busy));
    sew_master_model sew_master_model_i (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));
    task automatic conclude();
        if (num_errors == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic sb(input logic [7:0] b, output logic k);
        logic [7:0] r;
        sew_master_model_i.start();
        sew_master_model_i.xfer(b, 1'b0, r, k);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [2:0] k);
        logic [7:0] r;
        sb(8'hAA, k[2]);
        sew_master_model_i.xfer(a, 1'b0, r, k[1]);
        sew_master_model_i.xfer(d, 1'b0, r, k[0]);
        sew_master_model_i.stop();
    endtask
    task automatic rd(input logic [7:0] a, input logic rnd, output logic [7:0] v);
        logic k;
        if (rnd)
        begin
            sb(8'hAA, k);
            sew_master_model_i.xfer(a, 1'b0, v, k);
        end
        sb(8'hAB, k);
        sew_master_model_i.xfer(8'hFF, 1'b0, v, k);
        sew_master_model_i.stop();
    endtask
    task automatic poll(input logic e);
        logic a;
        sb(8'hAA, a);
        sew_master_model_i.stop();
        `CHK("poll_ack", e, a)
    endtask
    initial
    begin
        logic [2:0] k;
        logic       x, p;
        logic [7:0] v;
        repeat (5) @(negedge clk_i);
        reset_n_i = 1'b1;
        repeat (4) @(negedge clk_i);
        `CHK("busy_reset", 1'b0, busy)
        foreach (rows[i])
        begin
            write_protect_i = rows[i].wp;
            prog_enable_i = rows[i].en;
            x = rows[i].wp && rows[i].a[7];
            p = rows[i].en && !x;
            wr(rows[i].a, rows[i].d, k);
            `CHK("acks", x ? 3'b110 : 3'b111, k)
            `CHK("busy", p, busy)
            if (p)
            begin
                mem[rows[i].a] = rows[i].d;
                poll(1'b0);
                for (int n = 0; busy && n < 2 * WC; n++)
                    @(negedge clk_i);
                `CHK("busy_end", 1'b0, busy)
                poll(1'b1);
            end
            rd(rows[i].a, 1'b1, v);
            `CHK("rdata", mem[rows[i].a], v)
        end
        rd(8'h00, 1'b0, v);
        `CHK("cur_read", mem[8'h90], v)
        // sequential read: master acks the first byte, the counter moves on to the next word
        sb(8'hAA, x);
        sew_master_model_i.xfer(8'h8F, 1'b0, v, x);
        sb(8'hAB, x);
        sew_master_model_i.xfer(8'hFF, 1'b1, v, x);
        `CHK("seq_rd0", mem[8'h8F], v)
        sew_master_model_i.xfer(8'hFF, 1'b0, v, x);
        sew_master_model_i.stop();
        `CHK("seq_rd1", mem[8'h90], v)
        foreach (bad[i])
        begin
            // idle device answers its own address, so the refusal below is down to the address alone
            poll(1'b1);
            sb(bad[i], x);
            sew_master_model_i.stop();
            `CHK("bad_addr", 1'b0, x)
        end
        wr(8'h20, 8'h44, k);
        reset_n_i = 1'b0;
        repeat (2) @(negedge clk_i);
        `CHK("busy_cut", 1'b0, busy)
        reset_n_i = 1'b1;
        repeat (4) @(negedge clk_i);
        // reset cut the write short, so the device must answer again at once
        poll(1'b1);
        conclude();
    end
    initial
    begin
        #900000;
        num_errors++;
        conclude();
    end
endmodule // serial_eeprom_write_busy_protect_bench
`default_nettype wire
